/* ext_memory_model.sv */
// slow off-chip memory answering the strobed bus
// assumes strobe, address and data from the generator pins
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model (
    // clock
    input wire logic ref_clk,
    // bus pins
    input wire logic [18:0] ext_addr,
    input wire logic [15:0] ext_data_out,
    input wire logic ext_data_oe,
    input wire logic ext_strobe_n,
    input wire logic ext_read,
    output logic [15:0] ext_data_in
);
    logic [15:0] mem [16];
    logic [15:0] last_q = 16'h0;
    // released bus toggles so stale data never looks valid
    assign ext_data_in = (!ext_strobe_n && ext_read) ? mem[ext_addr[3:0]] : ~last_q;
    always_ff @(posedge ref_clk) begin
        last_q <= ext_data_in;
        if (!ext_strobe_n && ext_data_oe) begin
            mem[ext_addr[3:0]] <= ext_data_out;
        end
    end
endmodule : ext_memory_model
`default_nettype wire

/* external_wait_state_generator.sv */
// wait-state generator for the shared external memory interface of two subsystems
// assumes register ports and access requests are synchronous to ref_clk;
// the strap and external read data arrive from pins and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "wsg_defines.svh"
module external_wait_state_generator
    import wsg_pkg::*;
#(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 16,
    parameter int MMR_ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,

    // memory-mapped register ports, index 0 is subsystem A, 1 is B
    input wire logic [1:0] mmr_wr_en,
    input wire logic [1:0] mmr_rd_en,
    input wire logic [1:0][MMR_ADDR_W-1:0] mmr_addr,
    input wire logic [1:0][DATA_W-1:0] mmr_wdata,
    output logic [1:0][DATA_W-1:0] mmr_rdata,

    // external bus arbitration, high when subsystem B owns the bus
    input wire logic external_bus_arbitration,

    // strap pin enabling the external interface
    input wire logic external_interface_strap,

    // access request from the owning subsystem
    input wire logic xacc_req,
    input wire logic xacc_write,
    input wire logic [1:0] xacc_space,
    input wire logic [ADDR_W-1:0] xacc_addr,
    input wire logic [DATA_W-1:0] xacc_wdata,
    output logic xacc_ready,
    output logic xacc_done,
    output logic [DATA_W-1:0] xacc_rdata,

    // external bus pins
    output logic [ADDR_W-1:0] ext_addr,
    output logic [DATA_W-1:0] ext_data_out,
    output logic ext_data_oe,
    input wire logic [DATA_W-1:0] ext_data_in,
    output logic ext_strobe_n,
    output logic ext_read,
    output logic ext_prog_sel_n,
    output logic ext_data_sel_n,
    output logic ext_io_sel_n
);

    // per-subsystem register copies
    logic [1:0][DATA_W-1:0] ranges_q;
    logic [1:0] mult_q;
    localparam logic [DATA_W-1:0] CONTROL_RESET = DATA_W'(`WSG_CONTROL_RESET);

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_sub
            logic ranges_hit;
            logic control_hit;

            assign ranges_hit = (mmr_addr[s] == MMR_ADDR_W'(`WSG_RANGES_OFFSET)); // see RL16
            assign control_hit = (mmr_addr[s] == MMR_ADDR_W'(`WSG_CONTROL_OFFSET)); // see RL16

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    ranges_q[s] <= DATA_W'(`WSG_RANGES_RESET); // see RL3
                end else if (mmr_wr_en[s] && ranges_hit) begin
                    ranges_q[s] <= mmr_wdata[s]; // see RL2
                end
            end

            // only the multiplier bit is stored; the rest stays zero
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    mult_q[s] <= CONTROL_RESET[`WSG_MULT_BIT]; // see RL5
                end else if (mmr_wr_en[s] && control_hit) begin
                    mult_q[s] <= mmr_wdata[s][`WSG_MULT_BIT]; // see RL14
                end
            end

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    mmr_rdata[s] <= '0;
                end else if (mmr_rd_en[s]) begin
                    if (ranges_hit) begin
                        mmr_rdata[s] <= ranges_q[s];
                    end else if (control_hit) begin
                        mmr_rdata[s] <= {{(DATA_W-1){1'b0}}, mult_q[s]}; // see RL14
                    end else begin
                        mmr_rdata[s] <= '0;
                    end
                end
            end
        end
    endgenerate

    // strap synchroniser and capture shortly after reset release
    logic strap_meta_q;
    logic strap_sync_q;
    logic [1:0] settle_q;
    logic strap_taken_q;
    logic xif_enabled_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
        end else begin
            strap_meta_q <= external_interface_strap;
            strap_sync_q <= strap_meta_q;
        end
    end

    // the strap is latched once, so later pin changes do not disturb a running system
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            settle_q <= '0;
            strap_taken_q <= 1'b0;
            xif_enabled_q <= 1'b0;
        end else if (!strap_taken_q) begin
            if (settle_q == `WSG_STRAP_SETTLE) begin
                strap_taken_q <= 1'b1;
                xif_enabled_q <= strap_sync_q; // see RL18
            end else begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    // external read data synchroniser
    logic [DATA_W-1:0] rd_meta_q;
    logic [DATA_W-1:0] rd_sync_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_meta_q <= '0;
            rd_sync_q <= '0;
        end else begin
            rd_meta_q <= ext_data_in;
            rd_sync_q <= rd_meta_q;
        end
    end

    // settings of the subsystem that currently owns the bus
    logic [DATA_W-1:0] sel_ranges;
    logic sel_mult;

    assign sel_ranges = ranges_q[external_bus_arbitration]; // see RL15
    assign sel_mult = mult_q[external_bus_arbitration]; // see RL15

    // base count for the requested range
    logic [2:0] base;
    logic extended_program_range_bit;

    assign extended_program_range_bit = sel_ranges[`WSG_EXTENDED_PROGRAM_RANGE_BIT]; // see RL9

    always_comb begin
        base = `WSG_BASE_MAX;
        case (space_t'(xacc_space))
            SPACE_IO: begin
                base = sel_ranges[`WSG_IO_LSB +: 3]; // see RL6
            end
            SPACE_DATA: begin
                if (xacc_addr[15]) begin
                    base = sel_ranges[`WSG_DATA_HI_LSB +: 3]; // see RL7
                end else begin
                    base = sel_ranges[`WSG_DATA_LO_LSB +: 3]; // see RL8
                end
            end
            SPACE_PROG: begin
                if (!extended_program_range_bit) begin
                    if (xacc_addr[15]) begin
                        base = sel_ranges[`WSG_PROG_HI_LSB +: 3]; // see RL10
                    end else begin
                        base = sel_ranges[`WSG_PROG_LO_LSB +: 3]; // see RL12
                    end
                end else if (xacc_addr[ADDR_W-1] == 1'b0) begin
                    base = sel_ranges[`WSG_PROG_LO_LSB +: 3]; // see RL13
                end else begin
                    // above the covered range: slowest setting, upper field ignored
                    base = `WSG_BASE_MAX; // see RL11
                end
            end
            default: begin
                base = `WSG_BASE_MAX;
            end
        endcase
    end

    // total waits, 0 to 14
    logic [3:0] waits;

    assign waits = sel_mult ? {base, 1'b0} : {1'b0, base}; // see RL4 RL5 RL1

    // bus cycle sequencer
    state_t state_q;
    state_t state_d;
    logic cnt_load;
    logic cnt_expired;
    logic start;

    assign xacc_ready = (state_q == ST_IDLE) && strap_taken_q;
    assign start = xacc_req && xacc_ready;
    assign cnt_load = start;
    assign xacc_done = (state_q == ST_FINISH);

    wait_state_counter #(
        .WIDTH(4)
    ) u_wait_counter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .load(cnt_load),
        .load_value(waits),
        .expired(cnt_expired)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (cnt_expired) begin
                    state_d = ST_FINISH; // see RL17
                end
            end
            ST_FINISH: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // pin drive: address and data held for the whole stretched cycle
    logic drive_q;
    logic write_q;
    space_t space_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_addr <= '0;
            ext_data_out <= '0;
            write_q <= 1'b0;
            space_q <= SPACE_PROG;
        end else if (start) begin
            ext_addr <= xacc_addr;
            ext_data_out <= xacc_wdata;
            write_q <= xacc_write;
            space_q <= space_t'(xacc_space);
        end
    end

    // a disabled interface still times the cycle but never asserts the strobe, the space selects or the data enable
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_q <= 1'b0;
        end else if (start) begin
            drive_q <= xif_enabled_q; // see RL18
        end else if (state_q == ST_ACCESS && cnt_expired) begin
            drive_q <= 1'b0;
        end
    end

    assign ext_strobe_n = !drive_q; // see RL17
    assign ext_data_oe = drive_q && write_q; // see RL18
    assign ext_read = !write_q;
    assign ext_prog_sel_n = !(drive_q && space_q == SPACE_PROG);
    assign ext_data_sel_n = !(drive_q && space_q == SPACE_DATA);
    assign ext_io_sel_n = !(drive_q && space_q == SPACE_IO);

    // read data taken on the last waited cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            xacc_rdata <= '0;
        end else if (state_q == ST_ACCESS && cnt_expired && !write_q) begin
            if (xif_enabled_q) begin
                xacc_rdata <= rd_sync_q;
            end else begin
                xacc_rdata <= DATA_W'(`WSG_UNKNOWN_READ); // see RL18
            end
        end
    end

endmodule : external_wait_state_generator
`default_nettype wire

/* external_wait_state_generator_sva.sv */
// port checker for the wait-state generator
// assumes it is bound into the generator top module
`timescale 1ns/1ps
`default_nettype none
module wsg_checker #(
    parameter int DATA_W = 16,
    parameter int MMR_ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [1:0] mmr_rd_en,
    input wire logic [1:0][MMR_ADDR_W-1:0] mmr_addr,
    input wire logic [1:0][DATA_W-1:0] mmr_rdata,
    // access port
    input wire logic xacc_req,
    input wire logic xacc_ready,
    input wire logic xacc_done,
    // pins
    input wire logic ext_strobe_n,
    input wire logic ext_read,
    input wire logic ext_data_oe,
    input wire logic ext_prog_sel_n,
    input wire logic ext_data_sel_n,
    input wire logic ext_io_sel_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    one_select_a: assert property (!ext_strobe_n |-> $countones({ext_prog_sel_n, ext_data_sel_n, ext_io_sel_n}) == 2)
        else $error("space select not unique");
    oe_write_a: assert property (ext_data_oe |-> !ext_strobe_n && !ext_read)
        else $error("data driven outside a write");
    strobe_max_a: assert property ($fell(ext_strobe_n) |-> ##[1:15] ext_strobe_n)
        else $error("strobe longer than fifteen cycles");
    strobe_done_a: assert property ($rose(ext_strobe_n) |-> xacc_done)
        else $error("strobe ended without done");
    accept_done_a: assert property (xacc_req && xacc_ready |-> ##[2:16] xacc_done)
        else $error("access not finished in time");
    done_pulse_a: assert property (xacc_done |=> !xacc_done)
        else $error("done longer than one cycle");
    busy_refuse_a: assert property (xacc_done |-> !xacc_ready)
        else $error("ready while finishing");
    accept_busy_a: assert property (xacc_req && xacc_ready |=> !xacc_ready [*2])
        else $error("ready again right after acceptance");
    ctrl_reserved_a: assert property (mmr_rd_en[0] && mmr_addr[0] == 8'h2b |=> mmr_rdata[0][15:1] == 15'h0)
        else $error("reserved control bits set");
    rdata_hold_a: assert property (!mmr_rd_en[1] |=> $stable(mmr_rdata[1]))
        else $error("read data moved without a read");
    cover property (xacc_req && xacc_ready && !ext_read);
    cover property ($rose(ext_strobe_n) && ext_read);
    cover property (mmr_rd_en[1]);
endmodule : wsg_checker
bind external_wait_state_generator wsg_checker #(.DATA_W(DATA_W), .MMR_ADDR_W(MMR_ADDR_W)) u_wsg_checker (
    .ref_clk(ref_clk), .resetn(resetn), .mmr_rd_en(mmr_rd_en), .mmr_addr(mmr_addr),
    .mmr_rdata(mmr_rdata), .xacc_req(xacc_req), .xacc_ready(xacc_ready), .xacc_done(xacc_done),
    .ext_strobe_n(ext_strobe_n), .ext_read(ext_read), .ext_data_oe(ext_data_oe),
    .ext_prog_sel_n(ext_prog_sel_n), .ext_data_sel_n(ext_data_sel_n), .ext_io_sel_n(ext_io_sel_n));
`default_nettype wire

/* testbench.sv */
// self-checking bench for the wait-state generator
// assumes the memory model on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "wsg_defines.svh"
module testbench;
    logic ref_clk = 1'b0, resetn = 1'b0, arb = 1'b0, strap = 1'b1, req = 1'b0, xw = 1'b0, seen;
    logic [1:0] wr_en = 2'h0, rd_en = 2'h0, sp = 2'h0;
    logic [1:0][7:0] maddr = '0;
    logic [1:0][15:0] mwd = '0, mrd;
    logic [18:0] xa = 19'h0, ea;
    logic [15:0] xd = 16'h0, xrd, edo, edi;
    logic ready, done, eoe, estb_n, erd;
    logic psel_n, dsel_n, iosel_n;
    logic [2:0] sel = 3'h7;
    int miscompares = 0, checked = 0;
    external_wait_state_generator u_external_wait_state_generator (
        .ref_clk(ref_clk), .resetn(resetn), .mmr_wr_en(wr_en), .mmr_rd_en(rd_en), .mmr_addr(maddr),
        .mmr_wdata(mwd), .mmr_rdata(mrd), .external_bus_arbitration(arb), .external_interface_strap(strap),
        .xacc_req(req), .xacc_write(xw), .xacc_space(sp), .xacc_addr(xa), .xacc_wdata(xd),
        .xacc_ready(ready), .xacc_done(done), .xacc_rdata(xrd), .ext_addr(ea), .ext_data_out(edo),
        .ext_data_oe(eoe), .ext_data_in(edi), .ext_strobe_n(estb_n), .ext_read(erd),
        .ext_prog_sel_n(psel_n), .ext_data_sel_n(dsel_n), .ext_io_sel_n(iosel_n));
    ext_memory_model u_ext_memory_model (.ref_clk(ref_clk), .ext_addr(ea), .ext_data_out(edo),
        .ext_data_oe(eoe), .ext_strobe_n(estb_n), .ext_read(erd), .ext_data_in(edi));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task wr(input int s, input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1 wr_en[s] = 1'b1;
        maddr[s] = a;
        mwd[s] = d;
        @(posedge ref_clk);
        #1 wr_en[s] = 1'b0;
    endtask : wr
    task rd(input int s, input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        #1 rd_en[s] = 1'b1;
        maddr[s] = a;
        @(posedge ref_clk);
        #1 rd_en[s] = 1'b0;
        chk(mrd[s], e);
    endtask : rd
    // counts edges from request to done, which must be two plus the waits
    task acc(input logic w, input logic [1:0] s, input logic [18:0] a, input logic [15:0] d, input int wt,
             input logic [15:0] e);
        logic [15:0] n;
        n = 16'h0;
        seen = 1'b0;
        @(posedge ref_clk);
        #1;
        while (ready !== 1'b1 && n < 16'h14) begin
            @(posedge ref_clk);
            #1 n++;
        end
        req = 1'b1;
        xw = w;
        sp = s;
        xa = a;
        xd = d;
        n = 16'h0;
        while (done !== 1'b1 && n < 16'h28) begin
            @(posedge ref_clk);
            #1 req = 1'b0;
            n++;
            if (estb_n === 1'b0) begin
                seen = 1'b1;
                sel = {iosel_n, dsel_n, psel_n};
            end
        end
        chk(n, 16'(wt + 2));
        if (!w) chk(xrd, e);
        // space encoding: 0 program, 1 data, 2 I/O; exactly that select goes low
        if (seen === 1'b1) chk({13'h0, sel}, {13'h0, s != 2'h2, s != 2'h1, s != 2'h0});
    endtask : acc
    task conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        #100000 miscompares++;
        conclude();
    end
    initial begin
        static logic [1:0] ts [5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
        static logic [18:0] ta [5] = '{19'h0ffff, 19'h08000, 19'h07fff, 19'h18000, 19'h17fff};
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        rd(0, 8'h28, 16'h7fff);
        rd(1, 8'h28, 16'h7fff);
        rd(0, 8'h2b, 16'h0000);
        rd(0, 8'h30, 16'h0000);
        acc(1'b1, 2'h2, 19'h00005, 16'h1111, 7, 16'h0);
        acc(1'b0, 2'h2, 19'h00005, 16'h0, 7, 16'h1111);
        wr(0, 8'h2b, 16'hffff);
        rd(0, 8'h2b, 16'h0001);
        acc(1'b0, 2'h1, 19'h08005, 16'h0, 14, 16'h1111);
        wr(0, 8'h2b, 16'h0000);
        wr(0, 8'h28, 16'h14e5);
        rd(0, 8'h28, 16'h14e5);
        for (int i = 0; i < 5; i++) acc(1'b1, ts[i], ta[i], 16'h2222, i + 1, 16'h0);
        wr(0, 8'h2b, 16'h0001);
        acc(1'b1, 2'h2, 19'h00001, 16'h3333, 2, 16'h0);
        wr(0, 8'h2b, 16'h0000);
        wr(0, 8'h28, 16'h94e5);
        acc(1'b1, 2'h0, 19'h18000, 16'h4444, 5, 16'h0);
        acc(1'b1, 2'h0, 19'h40000, 16'h4444, 7, 16'h0);
        wr(1, 8'h28, 16'h0000);
        arb = 1'b1;
        acc(1'b1, 2'h1, 19'h08000, 16'h5555, 0, 16'h0);
        arb = 1'b0;
        acc(1'b1, 2'h1, 19'h08000, 16'h5555, 2, 16'h0);
        // strap is only sampled after reset, so a fresh reset is needed
        strap = 1'b0;
        resetn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        acc(1'b0, 2'h2, 19'h00005, 16'h0, 7, `WSG_UNKNOWN_READ);
        chk({15'h0, seen}, 16'h0);
        conclude();
    end
endmodule : testbench
`default_nettype wire

/* wait_state_counter.sv */
// down-counter that times the wait states of one external bus cycle
// assumes load and the count come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module wait_state_counter #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // status
    output logic expired
);

    logic [WIDTH-1:0] cnt_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - WIDTH'(1); // see RL17
        end
    end

    assign expired = (cnt_q == '0);

endmodule : wait_state_counter
`default_nettype wire

/* wsg_defines.svh */
// offsets, field positions, reset values and timing figures of the wait-state generator
// assumes a 16-bit memory-mapped register port per subsystem and a 125 MHz machine clock
// Summary of operation
// RL1 - external cycles stretch up to fourteen waits
// RL2 - five 3-bit base counts in low bits
// RL3 - reset gives seven waits everywhere
// RL4 - multiplier set doubles the base count
// RL5 - multiplier clear uses base count unchanged
// RL6 - bits 14-12 time all I/O accesses
// RL7 - bits 11-9 time upper data half
// RL8 - bits 8-6 time lower data half
// RL9 - bit 15 picks program field coverage
// RL10 - bit15 clear: bits 5-3 upper program half
// RL11 - bit15 set: bits 5-3 unused
// RL12 - bit15 clear: bits 2-0 lower program half
// RL13 - bit15 set: bits 2-0 cover 00000-3ffff
// RL14 - control bits 15-1 read zero, unwritable
// RL15 - arbitration picks subsystem A or B settings
// RL16 - ranges at 0028h, control at 002bh
// RL17 - hold external cycle base times multiplier
// RL18 - strap off: writes dropped, reads unknown
`ifndef WSG_DEFINES_SVH
`define WSG_DEFINES_SVH

`define WSG_RANGES_OFFSET 8'h28
`define WSG_CONTROL_OFFSET 8'h2b

`define WSG_RANGES_RESET 16'h7fff
`define WSG_CONTROL_RESET 16'h0000

`define WSG_EXTENDED_PROGRAM_RANGE_BIT 15
`define WSG_IO_LSB 12
`define WSG_DATA_HI_LSB 9
`define WSG_DATA_LO_LSB 6
`define WSG_PROG_HI_LSB 3
`define WSG_PROG_LO_LSB 0
`define WSG_MULT_BIT 0

`define WSG_MAX_WAITS 4'he
`define WSG_BASE_MAX 3'h7
`define WSG_UNKNOWN_READ 16'hdead
`define WSG_STRAP_SETTLE 2'h3

`endif

/* wsg_pkg.sv */
// types shared by the wait-state generator files
// assumes nothing beyond a SystemVerilog compiler
package wsg_pkg;

    typedef enum logic [1:0] {
        SPACE_PROG = 2'h0,
        SPACE_DATA = 2'h1,
        SPACE_IO = 2'h2
    } space_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ACCESS = 3'h2,
        ST_FINISH = 3'h4
    } state_t;

endpackage : wsg_pkg
